// ===== src/scl_loader.sv
// Loader that copies store words into per-port configuration fields
`timescale 1ns/1ns
`include "scl_regs.svh"

// ----------------------------------------------------------------------
// Store handshake and load sequence
// ----------------------------------------------------------------------
// The loader fetches one word at a time from the configuration store.
// The address register is loaded on the same edge that raises the request,
// so the store never sees a request with a moving address.
// The request then stands, with its address, until the store answers
// with a one-cycle valid pulse; that edge writes the word into its field.
// A valid pulse while no request stands is ignored, so a stray or late
// answer cannot land in a field.
// Between two words the request drops for one cycle; a store that
// answers by level rather than by pulse cannot be taken twice.
// Words come in ascending store address order; the last one raises
// the done flag, and nothing more is asked for until the next reset.
// Port 0 has no slot capability words, so its slot fields stay clear.

module scl_loader
    import scl_pkg::*;
#(
    parameter int NPORT = 6
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Store read port
    output logic o_rd_req,
    output logic [7:0] o_rd_addr,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data,
    // Loaded fields, one slice per port
    output logic [16*NPORT-1:0] o_slot_cap_lo,
    output logic [16*NPORT-1:0] o_slot_cap_hi,
    output logic [32*NPORT-1:0] o_port_vendor_ctrl_status_3,
    output logic [11:0] o_replay_cnt_p0,
    output logic [11:0] o_replay_cnt_p1,
    output logic [11:0] o_replay_cnt_p2,
    output logic [2:0] o_replay_user_en,
    output logic [5:0] o_rx_training_seq_count_ctl,
    // Load status
    output logic o_load_done
);

    // ------------------------------------------------------------------
    // Address list: slot lo (5), slot hi (5), vcs lo (6), vcs hi (6), replay (3)
    // ------------------------------------------------------------------
    localparam logic [4:0] NWORDS = 5'd25;

    // Maps a word sequence index to its store address
    function automatic logic [7:0] idx_to_addr(input logic [4:0] idx);
        logic [7:0] a;
        a = 8'h00;
        // Index within a group, doubled, gives the byte offset
        if (idx < 5'd5) begin
            // Slot capability low words, ports 1 to 5
            a = `SCL_ADDR_SLOT_LO_P1 + {idx[3:0], 1'b0};
        end else if (idx < 5'd10) begin
            // Slot capability high words, ports 1 to 5
            a = `SCL_ADDR_SLOT_HI_P1 + {idx - 5'd5, 1'b0};
        end else if (idx < 5'd16) begin
            // Vendor CSR low halves, ports 0 to 5
            a = `SCL_ADDR_VCS_LO_P0 + {idx - 5'd10, 1'b0};
        end else if (idx < 5'd22) begin
            // Vendor CSR high halves, ports 0 to 5
            a = `SCL_ADDR_VCS_HI_P0 + {idx - 5'd16, 1'b0};
        end else begin
            // Replay words, ports 0 to 2
            a = `SCL_ADDR_REPLAY_P0 + {idx - 5'd22, 1'b0};
        end
        return a;
    endfunction

    scl_state_t state; // Sequencer state
    logic [4:0] idx; // Current word index
    logic [7:0] cap_addr; // Address of the word in flight

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Load runs once after reset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= SCL_IDLE;
            idx <= 5'd0;
            o_rd_addr <= 8'h00;
        end else begin
            unique case (state)
                SCL_IDLE: begin
                    // One quiet cycle after reset
                    state <= SCL_REQ;
                end
                SCL_REQ: begin
                    // Address loads on the same edge that raises the request
                    o_rd_addr <= idx_to_addr(idx);
                    state <= SCL_WAIT;
                end
                SCL_WAIT: begin
                    // Word arrives, advance or finish
                    if (i_rd_valid) begin
                        if (idx == NWORDS - 5'd1) begin
                            // Last word taken, park
                            state <= SCL_DONE;
                        end else begin
                            // Next word of the list
                            idx <= idx + 5'd1;
                            state <= SCL_REQ;
                        end
                    end
                end
                SCL_DONE: begin
                    // Parked until the next reset
                    state <= SCL_DONE;
                end
            endcase
        end
    end

    // Request held while waiting for the word
    assign o_rd_req = (state == SCL_WAIT);
    // Address of the word being taken; the register only moves in the
    // request state, so it still names the word at the accept edge
    assign cap_addr = o_rd_addr;

    // Done flag gates port config responses
    // Done rises on the same edge that writes the last word
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_load_done <= 1'b0;
        end else if (state == SCL_WAIT && i_rd_valid && idx == NWORDS - 5'd1) begin
            o_load_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Per-port word capture
    // ------------------------------------------------------------------
    logic take; // A word is being accepted
    assign take = (state == SCL_WAIT) && i_rd_valid;

    // Each port decodes its own addresses; a word matches one field at most
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            // Reset clears every half; a taken word lands where it matches
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    o_slot_cap_lo[16*p +: 16] <= `SCL_RST_WORD;
                    o_slot_cap_hi[16*p +: 16] <= `SCL_RST_WORD;
                    o_port_vendor_ctrl_status_3[32*p +: 32] <= {2{`SCL_RST_WORD}};
                end else if (take) begin
                    if (p >= 1 && cap_addr == `SCL_ADDR_SLOT_LO_P1 + 8'(2*(p-1))) begin
                        o_slot_cap_lo[16*p +: 16] <= i_rd_data;
                    end
                    if (p >= 1 && cap_addr == `SCL_ADDR_SLOT_HI_P1 + 8'(2*(p-1))) begin
                        o_slot_cap_hi[16*p +: 16] <= i_rd_data;
                    end
                    if (cap_addr == `SCL_ADDR_VCS_LO_P0 + 8'(2*p)) begin
                        o_port_vendor_ctrl_status_3[32*p +: 16] <= i_rd_data;
                    end
                    if (cap_addr == `SCL_ADDR_VCS_HI_P0 + 8'(2*p)) begin
                        o_port_vendor_ctrl_status_3[32*p+16 +: 16] <= i_rd_data;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Replay words, ports 0 to 2
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_replay_cnt_p0 <= 12'h000;
            o_replay_cnt_p1 <= 12'h000;
            o_replay_cnt_p2 <= 12'h000;
            o_replay_user_en <= 3'h0;
            o_rx_training_seq_count_ctl <= 6'h00;
        end else if (take) begin
            if (cap_addr == `SCL_ADDR_REPLAY_P0) begin
                o_replay_cnt_p0 <= i_rd_data[`SCL_RPL_CNT_MSB:0];
                o_replay_user_en[0] <= i_rd_data[`SCL_RPL_EN_BIT];
                o_rx_training_seq_count_ctl[1:0] <=
                    i_rd_data[`SCL_RPL_TS_MSB:`SCL_RPL_TS_LSB];
            end
            if (cap_addr == `SCL_ADDR_REPLAY_P0 + `SCL_ADDR_STEP) begin
                o_replay_cnt_p1 <= i_rd_data[`SCL_RPL_CNT_MSB:0];
                o_replay_user_en[1] <= i_rd_data[`SCL_RPL_EN_BIT];
                o_rx_training_seq_count_ctl[3:2] <=
                    i_rd_data[`SCL_RPL_TS_MSB:`SCL_RPL_TS_LSB];
            end
            if (cap_addr == `SCL_ADDR_REPLAY_P0 + 8'h04) begin
                o_replay_cnt_p2 <= i_rd_data[`SCL_RPL_CNT_MSB:0];
                o_replay_user_en[2] <= i_rd_data[`SCL_RPL_EN_BIT];
                o_rx_training_seq_count_ctl[5:4] <=
                    i_rd_data[`SCL_RPL_TS_MSB:`SCL_RPL_TS_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // Limitations
    // ------------------------------------------------------------------
    // Replay words of ports 3 to 5 and the other store words are not
    // fetched here; their fields keep their reset values.
    // A store that never answers holds the loader in the wait state and
    // the done flag low, which keeps the ports from answering.
    // The store sees no reset; an answer still in flight when reset falls
    // is ignored, since no request stands in the idle and request states.

endmodule

// ===== src/scl_pkg.sv
// Types for the switch port config word loader
package scl_pkg;
    // Loader sequencing states
    typedef enum logic [1:0] {
        SCL_IDLE = 2'b00,
        SCL_REQ = 2'b01,
        SCL_WAIT = 2'b10,
        SCL_DONE = 2'b11
    } scl_state_t;
endpackage

// ===== src/scl_regs.svh
// Address map and field positions for the switch port config word loader
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH

// ----------------------------------------------------------------------
// Store word addresses (byte addresses, words at even addresses)
// ----------------------------------------------------------------------
`define SCL_ADDR_SLOT_LO_P1 8'h92
`define SCL_ADDR_SLOT_HI_P1 8'ha2
`define SCL_ADDR_VCS_LO_P0 8'hb0
`define SCL_ADDR_VCS_HI_P0 8'hc0
`define SCL_ADDR_REPLAY_P0 8'hd0
`define SCL_ADDR_STEP 8'h02

// ----------------------------------------------------------------------
// Replay word fields
// ----------------------------------------------------------------------
`define SCL_RPL_CNT_MSB 11
`define SCL_RPL_EN_BIT 12
`define SCL_RPL_TS_MSB 14
`define SCL_RPL_TS_LSB 13

// ----------------------------------------------------------------------
// Reset values of loaded fields
// ----------------------------------------------------------------------
`define SCL_RST_WORD 16'h0000

`endif

// ===== tb/scl_loader_asserts.sv
// Checker on the loader ports
`timescale 1ns/1ns
module scl_loader_asserts #(
    parameter int NPORT = 6
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic o_rd_req,
    input wire logic [7:0] o_rd_addr,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data,
    input wire logic [16*NPORT-1:0] o_slot_cap_lo,
    input wire logic [16*NPORT-1:0] o_slot_cap_hi,
    input wire logic [32*NPORT-1:0] o_port_vendor_ctrl_status_3,
    input wire logic [11:0] o_replay_cnt_p0,
    input wire logic [11:0] o_replay_cnt_p1,
    input wire logic [11:0] o_replay_cnt_p2,
    input wire logic [2:0] o_replay_user_en,
    input wire logic [5:0] o_rx_training_seq_count_ctl,
    input wire logic o_load_done
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Address and word of the last cycle
    logic [7:0] a_q;
    logic [15:0] d_q;
    always_ff @(posedge i_sys_clk) begin
        a_q <= o_rd_addr;
        d_q <= i_rd_data;
    end
    function automatic logic [15:0] w16(input logic [191:0] v, input int i);
        return v[16*i+:16];
    endfunction
    function automatic logic [7:0] nx(input logic [7:0] a);
        return a == 8'h9a ? 8'ha2 : a == 8'haa ? 8'hb0 : a == 8'hba ? 8'hc0 :
            a == 8'hca ? 8'hd0 : a + 8'h2;
    endfunction
    // Replay count of the port that a replay address names
    function automatic logic [11:0] cnt_of(input logic [7:0] a, input logic [11:0] c0,
        input logic [11:0] c1, input logic [11:0] c2);
        return a == 8'hd0 ? c0 : a == 8'hd2 ? c1 : c2;
    endfunction
    sequence take_in(logic [7:0] lo, logic [7:0] hi);
        o_rd_req && i_rd_valid && o_rd_addr inside {[lo:hi]};
    endsequence
    sequence rereq;
        !o_rd_req ##1 o_rd_req;
    endsequence
    // Request and address stand until the word is answered
    a_rd_hold: assert property (
        o_rd_req && !i_rd_valid |=> o_rd_req && $stable(o_rd_addr)) else $error("rd dropped");
    // One cycle low after each accept but the last, then the next address in order
    a_addr_next: assert property (
        take_in(8'h92, 8'hd2) |=> rereq ##0 o_rd_addr == nx($past(o_rd_addr, 2)))
        else $error("bad next addr");
    a_slot_lo: assert property (
        take_in(8'h92, 8'h9a) |=>
        w16({96'h0, o_slot_cap_lo}, (a_q - 8'h90) >> 1) == d_q)
        else $error("slot lo");
    a_slot_hi: assert property (
        take_in(8'ha2, 8'haa) |=>
        w16({96'h0, o_slot_cap_hi}, (a_q - 8'ha0) >> 1) == d_q)
        else $error("slot hi");
    a_vcs_lo: assert property (
        take_in(8'hb0, 8'hba) |=> w16(o_port_vendor_ctrl_status_3, a_q - 8'hb0) == d_q)
        else $error("vcs lo");
    a_vcs_hi: assert property (
        take_in(8'hc0, 8'hca) |=> w16(o_port_vendor_ctrl_status_3, a_q - 8'hbf) == d_q)
        else $error("vcs hi");
    a_rpl_word: assert property (
        take_in(8'hd0, 8'hd4) |=> o_replay_user_en[(a_q - 8'hd0) >> 1] == d_q[12] &&
        o_rx_training_seq_count_ctl[a_q - 8'hd0 +: 2] == d_q[14:13]) else $error("replay");
    a_rpl_cnt: assert property (
        take_in(8'hd0, 8'hd4) |=>
        cnt_of(a_q, o_replay_cnt_p0, o_replay_cnt_p1, o_replay_cnt_p2) == d_q[11:0])
        else $error("replay count");
    a_done_last: assert property (
        take_in(8'hd4, 8'hd4) |=> o_load_done && !o_rd_req) else $error("done late");
    // Port 0 has no slot words, its slot fields stay clear
    a_slot_p0_zero: assert property (
        o_slot_cap_lo[15:0] == 16'h0 && o_slot_cap_hi[15:0] == 16'h0)
        else $error("slot p0 written");
    // Done stays up and no request follows it
    a_done_hold: assert property (
        o_load_done |=> o_load_done && !o_rd_req) else $error("done dropped");
endmodule
bind scl_loader scl_loader_asserts #(.NPORT(NPORT)) chk_u (.*);

// ===== tb/scl_loader_test.sv
// Bench for the store word loader
`timescale 1ns/1ns
module scl_loader_test;
    logic i_sys_clk = 0, i_rst = 1, slow = 0, i_rd_valid, o_rd_req, o_load_done;
    logic [7:0] o_rd_addr;
    logic [15:0] i_rd_data;
    logic [95:0] o_slot_cap_lo, o_slot_cap_hi;
    logic [191:0] o_port_vendor_ctrl_status_3;
    logic [11:0] o_replay_cnt_p0, o_replay_cnt_p1, o_replay_cnt_p2;
    logic [2:0] o_replay_user_en;
    logic [5:0] o_rx_training_seq_count_ctl;
    int errors = 0, n_checks = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    scl_loader dut_u (.*);
    scl_store_model store_u (.i_sys_clk(i_sys_clk), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr),
        .i_slow(slow), .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data));
    function automatic logic [15:0] word_of(input logic [7:0] a);
        return {{a[4:0], a[7:5]} ^ 8'h5a, a};
    endfunction
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Full load after reset, then every field compared
    task automatic t_load(input logic s);
        logic [15:0] w;
        logic [11:0] c;
        @(posedge i_sys_clk);
        slow <= s;
        i_rst <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 500 && o_load_done !== 1'b1; k++) @(negedge i_sys_clk);
        chk("done", 16'h1, {15'h0, o_load_done});
        chk("req_after", 16'h0, {15'h0, o_rd_req});
        // Port 0 has no slot words and must stay clear
        for (int p = 0; p < 6; p++) begin
            w = p ? word_of(8'(8'h90 + 2 * p)) : 16'h0;
            chk("slot_lo", w, o_slot_cap_lo[16*p+:16]);
            w = p ? word_of(8'(8'ha0 + 2 * p)) : 16'h0;
            chk("slot_hi", w, o_slot_cap_hi[16*p+:16]);
            w = word_of(8'(8'hb0 + 2 * p));
            chk("vcs_lo", w, o_port_vendor_ctrl_status_3[32*p+:16]);
            w = word_of(8'(8'hc0 + 2 * p));
            chk("vcs_hi", w, o_port_vendor_ctrl_status_3[32*p+16+:16]);
        end
        // Replay fields of ports 0 to 2
        for (int p = 0; p < 3; p++) begin
            w = word_of(8'(8'hd0 + 2 * p));
            c = p == 0 ? o_replay_cnt_p0 : p == 1 ? o_replay_cnt_p1 : o_replay_cnt_p2;
            chk("rpl_cnt", {4'h0, w[11:0]}, {4'h0, c});
            chk("rpl_en", {15'h0, w[12]}, {15'h0, o_replay_user_en[p]});
            c = {10'h0, o_rx_training_seq_count_ctl[2*p+:2]};
            chk("rpl_ts", {14'h0, w[14:13]}, {4'h0, c});
        end
    endtask
    // Reset in mid-load clears the port 1 slot low field, the request and done
    task automatic t_mid_reset;
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        // Some words are in by now, the load is still running
        repeat (30) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("mid_slot", word_of(8'h92), o_slot_cap_lo[31:16]);
        chk("mid_done", 16'h0, {15'h0, o_load_done});
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("rst_req", 16'h0, {15'h0, o_rd_req});
        chk("rst_slot", 16'h0, o_slot_cap_lo[31:16]);
        chk("rst_done", 16'h0, {15'h0, o_load_done});
    endtask
    initial begin
        t_load(1'b0);
        t_load(1'b0);
        t_mid_reset();
        t_load(1'b1);
        give_verdict();
    end
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule

// ===== tb/scl_store_model.sv
// Behavioural config store answering word reads
`timescale 1ns/1ns
module scl_store_model (
    input wire logic i_sys_clk,
    input wire logic i_rd_req,
    input wire logic [7:0] i_rd_addr,
    input wire logic i_slow,
    output logic o_rd_valid = 1'b0,
    output logic [15:0] o_rd_data = 16'h0
);
    logic [1:0] wait_cnt = 2'h0;
    // One pulse per request; slow mode stalls three cycles
    always @(posedge i_sys_clk) begin
        o_rd_valid <= 1'b0;
        o_rd_data <= ~o_rd_data;
        if (i_rd_req && !o_rd_valid && wait_cnt == (i_slow ? 2'h3 : 2'h0)) begin
            o_rd_valid <= 1'b1;
            // High byte rotated so replay bits 12 to 14 differ per port
            o_rd_data <= {{i_rd_addr[4:0], i_rd_addr[7:5]} ^ 8'h5a, i_rd_addr};
            wait_cnt <= 2'h0;
        end else if (i_rd_req && !o_rd_valid) begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule
